//--- verilog/sra_pkg.sv
// Purpose: Shared constants and types for the search accelerator line driver.
// Assumes: A 10 MHz core clock and regular bus speed timing.
// Notes: All timing counts derive from printed times and the clock period.
package sra_pkg;
	// ==================================================
	// Clock and bus timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SLOT_NS = 70000;
	localparam int T_LOW1_NS = 6000;
	localparam int T_LOW0_NS = 60000;
	localparam int T_SAMPLE_NS = 15000;
	localparam int T_RST_LOW_NS = 480000;
	localparam int T_RST_SAMPLE_NS = 550000;
	localparam int T_RST_TOTAL_NS = 960000;
	localparam int TW = 14;
	localparam logic [TW-1:0] SLOT_CYC = TW'(T_SLOT_NS / CLK_PERIOD_NS);
	localparam logic [TW-1:0] LOW1_CYC = TW'((T_LOW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TW-1:0] LOW0_CYC = TW'((T_LOW0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TW-1:0] SAMPLE_CYC = TW'(T_SAMPLE_NS / CLK_PERIOD_NS);
	localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_SAMPLE_CYC = T_RST_SAMPLE_NS / CLK_PERIOD_NS;
	localparam int RST_TOTAL_CYC = T_RST_TOTAL_NS / CLK_PERIOD_NS;
	// ==================================================
	// Host codes and fields
	localparam logic [7:0] CODE_DATA_MODE = 8'hE1;
	localparam logic [7:0] CODE_CMD_MODE = 8'hE3;
	localparam logic [2:0] OP_ACCEL = 3'h5;
	localparam logic [2:0] OP_RESET = 3'h6;
	localparam int ACCEL_FLAG_BIT = 4;
	localparam logic [5:0] RESET_RESP_HI = 6'h33;
	localparam logic [1:0] RESP_PRESENT = 2'h1;
	localparam logic [1:0] RESP_ABSENT = 2'h3;
	localparam logic [1:0] LAST_PHASE = 2'h2;
	localparam logic [1:0] LAST_POS = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int FIFO_DEPTH = 16;
	// ==================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_SLOT = 3'b010,
		ST_RESET = 3'b011,
		ST_PUSH = 3'b100
	} sra_state_t;
endpackage : sra_pkg

//--- verilog/sra_stream_if.sv
// Purpose: Valid and ready byte stream between the sequencer and its FIFO.
// Assumes: One clock domain.
// Notes: A word moves on a cycle with valid and ready both high.
`timescale 1ns/1ps
interface sra_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : sra_stream_if

//--- verilog/sra_fifo.sv
// Purpose: Response FIFO with a registered output stage.
// Assumes: DEPTH is a power of two, at least two.
// Notes: The output register holds one word beyond DEPTH.
`timescale 1ns/1ps
module sra_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Streams
	sra_stream_if.snk in_s,
	sra_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("sra_fifo depth must be a power of two");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_s.ready = (count < (AW+1)'(DEPTH));
	assign push = in_s.valid && in_s.ready;
	assign pop = (count != '0) && (!out_s.valid || out_s.ready);
	// ==================================================
	// Storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_s.data;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// ==================================================
	// Output register
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			out_s.valid <= 1'b0;
			out_s.data <= '0;
		end else if (pop) begin
			out_s.valid <= 1'b1;
			out_s.data <= mem[rd_ptr];
		end else if (out_s.ready) begin
			out_s.valid <= 1'b0;
		end
	end
endmodule : sra_fifo

//--- verilog/sra_top.sv
// Purpose: Host byte sequencer with search accelerator for a single-wire bus.
// Assumes: Host bytes arrive already deserialised on core_clk; bus pin is open drain.
// Notes: Only regular speed timing is generated; the speed field is only stored.
`timescale 1ns/1ps
module sra_top
	import sra_pkg::*;
#(
	parameter logic [TW-1:0] RST_LOW = TW'(RST_LOW_CYC),
	parameter logic [TW-1:0] RST_SAMPLE = TW'(RST_SAMPLE_CYC),
	parameter logic [TW-1:0] RST_TOTAL = TW'(RST_TOTAL_CYC)
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Host byte stream in
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// Response byte stream out
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// Bus pin, open drain
	input wire logic bus_in,
	output logic bus_out,
	output logic bus_oe,
	// Status
	output logic data_mode,
	output logic accel_on,
	output logic [1:0] bus_speed
);
	generate
		if (RST_LOW >= RST_SAMPLE || RST_SAMPLE >= RST_TOTAL) begin : g_bad_reset
			$error("sra_top reset timing must rise strictly");
		end
	endgenerate
	sra_state_t state;
	logic [7:0] hold;
	logic [7:0] resp;
	logic [TW-1:0] tcnt;
	logic [1:0] phase;
	logic [1:0] pos;
	logic [2:0] bidx;
	logic first_read_slot;
	logic second_read_slot;
	logic search_err;
	logic bus_meta;
	logic bus_s;
	logic path_write_slot;
	logic slot_bit;
	logic slot_last;
	logic conflict;
	logic no_resp;
	sra_stream_if #(.WIDTH(8)) push_s ();
	sra_stream_if #(.WIDTH(8)) pop_s ();
	// ==================================================
	// Pin synchroniser
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bus_meta <= 1'b1;
			bus_s <= 1'b1;
		end else begin
			bus_meta <= bus_in;
			bus_s <= bus_meta;
		end
	end
	// ==================================================
	// Slot decisions
	always_comb begin
		conflict = !first_read_slot && !second_read_slot;
		no_resp = first_read_slot && second_read_slot;
		if (search_err || no_resp) begin
			path_write_slot = 1'b1;
		end else if (conflict) begin
			path_write_slot = hold[{pos, 1'b1}];
		end else begin
			path_write_slot = first_read_slot;
		end
		if (accel_on) begin
			slot_bit = (phase == LAST_PHASE) ? path_write_slot : 1'b1;
			slot_last = (phase == LAST_PHASE) && (pos == LAST_POS);
		end else begin
			slot_bit = hold[bidx];
			slot_last = (bidx == LAST_BIT);
		end
	end
	// ==================================================
	// Sequencer
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			hold <= 8'h00;
			tcnt <= '0;
			phase <= 2'h0;
			pos <= 2'h0;
			bidx <= 3'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (rx_valid && rx_ready) begin
						hold <= rx_data;
						state <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					tcnt <= '0;
					phase <= 2'h0;
					pos <= 2'h0;
					bidx <= 3'h0;
					if (data_mode) begin
						state <= (hold == CODE_CMD_MODE) ? ST_IDLE : ST_SLOT;
					end else if (hold[7:5] == OP_RESET) begin
						state <= ST_RESET;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_SLOT: begin
					if (tcnt == SLOT_CYC - 1'b1) begin
						tcnt <= '0;
						if (slot_last) begin
							state <= ST_PUSH;
						end else if (accel_on) begin
							phase <= (phase == LAST_PHASE) ? 2'h0 : phase + 1'b1;
							pos <= (phase == LAST_PHASE) ? pos + 1'b1 : pos;
						end else begin
							bidx <= bidx + 1'b1;
						end
					end else begin
						tcnt <= tcnt + 1'b1;
					end
				end
				ST_RESET: begin
					tcnt <= tcnt + 1'b1;
					if (tcnt == RST_TOTAL - 1'b1) begin
						state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					// Waiting here holds the host off while the FIFO is full.
					if (push_s.ready) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
	// ==================================================
	// Mode and accelerator flags
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			data_mode <= 1'b0;
			accel_on <= 1'b0;
			bus_speed <= 2'h0;
			search_err <= 1'b0;
		end else if (state == ST_DECODE) begin
			if (data_mode) begin
				data_mode <= (hold != CODE_CMD_MODE);
			end else if (hold == CODE_DATA_MODE) begin
				data_mode <= 1'b1;
			end else if (hold[7:5] == OP_ACCEL) begin
				accel_on <= hold[ACCEL_FLAG_BIT];
				bus_speed <= hold[3:2];
				if (!hold[ACCEL_FLAG_BIT]) begin
					search_err <= 1'b0;
				end
			end
		end else if (state == ST_SLOT && accel_on && phase == LAST_PHASE && tcnt == SAMPLE_CYC && no_resp) begin
			search_err <= 1'b1;
		end
	end
	// ==================================================
	// Read capture and response assembly
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			resp <= 8'h00;
			first_read_slot <= 1'b1;
			second_read_slot <= 1'b1;
		end else if (state == ST_DECODE) begin
			resp <= 8'h00;
		end else if (state == ST_SLOT && tcnt == SAMPLE_CYC) begin
			if (!accel_on) begin
				resp[bidx] <= bus_s;
			end else if (phase == 2'h0) begin
				first_read_slot <= bus_s;
			end else if (phase == 2'h1) begin
				second_read_slot <= bus_s;
			end else begin
				// flag on conflict or no response
				resp[{pos, 1'b0}] <= conflict || no_resp;
				resp[{pos, 1'b1}] <= path_write_slot;
			end
		end else if (state == ST_RESET && tcnt == RST_SAMPLE) begin
			resp <= {RESET_RESP_HI, bus_s ? RESP_ABSENT : RESP_PRESENT};
		end
	end
	// ==================================================
	// Pin driver
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bus_oe <= 1'b0;
			bus_out <= 1'b0;
		end else if (state == ST_SLOT) begin
			// twelve or eight slots per byte
			if (tcnt == '0) begin
				bus_oe <= 1'b1;
			end else if (tcnt == (slot_bit ? LOW1_CYC : LOW0_CYC)) begin
				bus_oe <= 1'b0;
			end
		end else if (state == ST_RESET) begin
			bus_oe <= (tcnt < RST_LOW);
		end else begin
			bus_oe <= 1'b0;
		end
	end
	// ==================================================
	// Host handshake
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_ready <= 1'b0;
		end else begin
			// next byte taken only after answer queued
			rx_ready <= (state == ST_IDLE) && !(rx_valid && rx_ready);
		end
	end
	// one response byte per data byte
	assign push_s.valid = (state == ST_PUSH);
	assign push_s.data = resp;
	assign pop_s.ready = tx_ready;
	assign tx_valid = pop_s.valid;
	assign tx_data = pop_s.data;
	sra_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_s(push_s),
		.out_s(pop_s)
	);
endmodule : sra_top

//--- bench/sra_top_properties.sv
// Purpose: Port checks for sra_top.
// Assumes: One clock, synchronous active low reset.
// Notes: Bound to every sra_top instance.
`timescale 1ns/1ps
module sra_properties
	import sra_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Host streams
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	// Bus and status
	input wire logic bus_in,
	input wire logic bus_out,
	input wire logic bus_oe,
	input wire logic data_mode,
	input wire logic accel_on,
	input wire logic [1:0] bus_speed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic take;
	logic oe_q;
	logic acc_byte;
	logic nrm_byte;
	logic [3:0] slots;
	assign take = rx_valid && rx_ready;
	always_ff @(posedge core_clk) begin
		oe_q <= bus_oe;
	end
	// ====
	// Slot count per byte, so a short or long sequence is caught.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			slots <= 4'h0;
			acc_byte <= 1'b0;
			nrm_byte <= 1'b0;
		end else if (take) begin
			slots <= 4'h0;
			acc_byte <= data_mode && accel_on && rx_data != CODE_CMD_MODE;
			nrm_byte <= data_mode && !accel_on && rx_data != CODE_CMD_MODE;
		end else if (bus_oe && !oe_q) begin
			slots <= slots + 4'h1;
		end
	end
	// The byte is decoded one cycle after it is taken, so flags show two cycles after the take.
	AST_RX_DROP: assert property (take |=> !rx_ready) else $error("rx_ready held after take");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("response changed before taken");
	AST_ACC_CMD: assert property (take && !data_mode && rx_data[7:5] == OP_ACCEL |-> ##2
		accel_on == $past(rx_data[4], 2) && bus_speed == $past(rx_data[3:2], 2)) else $error("accel flag wrong");
	AST_ACC_QUIET: assert property (take && !data_mode && rx_data[7:5] == OP_ACCEL && !tx_valid |=>
		!tx_valid [*8]) else $error("accel code answered");
	AST_TO_DATA: assert property (take && !data_mode && rx_data == CODE_DATA_MODE |-> ##2 data_mode)
		else $error("no data mode");
	AST_TO_CMD: assert property (take && data_mode && rx_data == CODE_CMD_MODE |-> ##2 !data_mode)
		else $error("no command mode");
	AST_IDLE_BUS: assert property (rx_ready |-> !bus_oe) else $error("bus driven while idle");
	AST_SLOT_LOW: assert property ($rose(bus_oe) |-> bus_oe [*8]) else $error("slot low too short");
	AST_SLOTS12: assert property ($rose(rx_ready) && acc_byte |-> slots == 4'hC)
		else $error("accel byte slot count");
	AST_SLOTS8: assert property ($rose(rx_ready) && nrm_byte |-> slots == 4'h8)
		else $error("plain byte slot count");
	AST_BUS_OUT: assert property (!bus_out) else $error("open drain output driven high");
endmodule : sra_properties
bind sra_top sra_properties u_props (.core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .data_mode(data_mode), .accel_on(accel_on),
	.bus_speed(bus_speed));

//--- bench/sra_bus_model.sv
// Purpose: Two search-capable bus devices plus presence answer.
// Assumes: Regular slot timing; a low of 4000 cycles or more is a reset.
// Notes: Devices keep following writes while en is low, they only stop answering.
// Notes: The eight slots after each reset carry the search command and get no answer.
`timescale 1ns/1ps
module sra_bus_model #(
	parameter logic [63:0] ID_A = 64'h0,
	parameter logic [63:0] ID_B = 64'h0
) (
	input wire logic core_clk,
	input wire logic en,
	input wire logic bus_oe,
	output logic pull
);
	localparam int CMD_SLOTS = 8;
	logic oe_q = 1'b0;
	logic rd;
	logic [1:0] act = 2'h3;
	int low = 0;
	int age = 1000;
	int pres = 0;
	int sc = -1;
	always @(posedge core_clk) begin
		if (!bus_oe && oe_q && low >= 4000) begin
			act = 2'h3;
			sc = -CMD_SLOTS - 1;
			pres = 1500;
		end
		if (bus_oe && !oe_q) begin
			sc = sc + 1;
			age = 0;
		end
		if (age == 300 && sc % 3 == 2)
			act = act & {ID_B[sc / 3] == !bus_oe, ID_A[sc / 3] == !bus_oe};
		rd = sc % 3 == 0 ? |(act & ~{ID_B[sc / 3], ID_A[sc / 3]}) : |(act & {ID_B[sc / 3], ID_A[sc / 3]});
		pull <= en && (pres > 0 || (sc >= 0 && age < 300 && sc % 3 != 2 && rd));
		low = bus_oe ? low + 1 : 0;
		age = age + 1;
		pres = pres > 0 ? pres - 1 : 0;
		oe_q = bus_oe;
	end
endmodule : sra_bus_model

//--- bench/tb_top.sv
// Purpose: Self-checking bench for sra_top.
// Assumes: Default reset timing; two bytes per pass, since a full pass would not fit the cycle budget.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
	import sra_pkg::*;
	localparam logic [63:0] ID_A = 64'h6AF;
	localparam logic [63:0] ID_B = 64'h95F;
	localparam int NPOS = 8;
	logic core_clk, resetn, rx_valid, rx_ready, tx_valid, tx_ready, bus_out, bus_oe;
	logic data_mode, accel_on, en, pull;
	logic [7:0] rx_data, tx_data;
	logic [1:0] bus_speed;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [NPOS-1:0] found, flags, path1;
	int hi1;
	sra_top u_dut (.core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.bus_in(!bus_oe && !pull), .bus_out(bus_out), .bus_oe(bus_oe), .data_mode(data_mode),
		.accel_on(accel_on), .bus_speed(bus_speed));
	sra_bus_model #(.ID_A(ID_A), .ID_B(ID_B)) u_bus (.core_clk(core_clk), .en(en), .bus_oe(bus_oe),
		.pull(pull));
	always #50 core_clk = !core_clk;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic idle();
		int i;
		for (i = 0; i < 20000 && rx_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : idle
	task automatic send(input logic [7:0] b, input logic on = 1'b1);
		idle();
		en = on;
		rx_data = b;
		rx_valid = 1'b1;
		@(negedge core_clk);
		rx_valid = 1'b0;
	endtask : send
	task automatic recv(input logic [7:0] e, output logic [7:0] got);
		int i;
		for (i = 0; i < 20000 && tx_valid !== 1'b1; i++) @(negedge core_clk);
		if (i == 20000) begin
			error_cnt++;
			report_and_stop();
		end
		got = tx_data;
		check(tx_data, e, "response");
		tx_ready = 1'b1;
		@(negedge core_clk);
		tx_ready = 1'b0;
		// One edge passes with ready low, so a following call never raises it in the same step.
		@(negedge core_clk);
	endtask : recv
	function automatic int highest(input logic [NPOS-1:0] f);
		int m;
		m = -1;
		for (int k = 0; k < NPOS; k++)
			if (f[k] === 1'b1)
				m = k;
		return m;
	endfunction : highest
	function automatic logic [NPOS-1:0] next_path(input logic [NPOS-1:0] prev, input int m);
		logic [NPOS-1:0] p;
		p = prev;
		for (int k = 0; k < NPOS; k++)
			if (k > m)
				p[k] = 1'b0;
		if (m >= 0)
			p[m] = 1'b1;
		return p;
	endfunction : next_path
	// Reset, search command as a plain byte, then accelerator on in data mode.
	task automatic start_search(input logic present, input logic [7:0] accel_cmd);
		logic [7:0] got;
		send(8'hC1, present);
		recv(present ? 8'hCD : 8'hCF, got);
		send(CODE_DATA_MODE);
		send(8'hF0);
		recv(8'hF0, got);
		send(CODE_CMD_MODE);
		send(accel_cmd);
		send(CODE_DATA_MODE);
		idle();
		check({3'h0, tx_valid, accel_on, data_mode, bus_speed}, {6'h03, accel_cmd[3:2]}, "mode state");
	endtask : start_search
	task automatic end_search();
		send(CODE_CMD_MODE);
		send(8'hA1);
		send(CODE_DATA_MODE);
		send(CODE_CMD_MODE);
		idle();
		check({3'h0, tx_valid, accel_on, data_mode, bus_speed}, 8'h00, "search off");
	endtask : end_search
	// Far side stalls for the whole pass, so responses pile up in the FIFO.
	task automatic pass(input logic [NPOS-1:0] path, input int off, output logic [NPOS-1:0] chosen,
		output logic [NPOS-1:0] flag);
		logic [1:0] act;
		logic rd_first, rd_second, wr, err;
		logic [7:0] e [NPOS / 4];
		logic [7:0] got;
		int n;
		act = 2'h3;
		err = 1'b0;
		for (n = 0; n < NPOS; n++) begin
			rd_first = n / 4 == off || !(|(act & ~{ID_B[n], ID_A[n]}));
			rd_second = n / 4 == off || !(|(act & {ID_B[n], ID_A[n]}));
			err = err || (rd_first && rd_second);
			wr = err ? 1'b1 : (rd_first || rd_second) ? rd_first : path[n];
			e[n / 4][2 * (n % 4)] = rd_first == rd_second;
			e[n / 4][2 * (n % 4) + 1] = wr;
			act = act & {ID_B[n] == wr, ID_A[n] == wr};
		end
		for (n = 0; n < NPOS / 4; n++)
			send({path[4 * n + 3], 1'b0, path[4 * n + 2], 1'b0, path[4 * n + 1], 1'b0, path[4 * n], 1'b0}, n != off);
		for (n = 0; n < NPOS / 4; n++) begin
			recv(e[n], got);
			chosen[4 * n +: 4] = {got[7], got[5], got[3], got[1]};
			flag[4 * n +: 4] = {got[6], got[4], got[2], got[0]};
		end
		idle();
		check({7'h0, tx_valid}, 8'h00, "extra response");
	endtask : pass
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		en = 1'b1;
		repeat (10) @(negedge core_clk);
		check({rx_ready, tx_valid, bus_oe, bus_out, data_mode, accel_on, bus_speed}, 8'h00, "reset");
		check(tx_data, 8'h00, "reset data");
		resetn = 1'b1;
		@(negedge core_clk);
		start_search(1'b1, 8'hB5);
		pass('0, -1, found, flags);
		end_search();
		check(found, ID_A[NPOS-1:0], "first identity");
		hi1 = highest(flags);
		path1 = next_path('0, hi1);
		start_search(1'b1, 8'hB1);
		pass(path1, -1, found, flags);
		end_search();
		check(found, ID_B[NPOS-1:0], "second identity");
		check(8'(highest(flags)), 8'(hi1), "search end");
		// No presence answer, and a silent first byte forces a bus error.
		start_search(1'b0, 8'hB1);
		pass('0, 0, found, flags);
		end_search();
		check({6'h0, found[NPOS-1], flags[NPOS-1]}, 8'h03, "failed pass");
		report_and_stop();
	end
endmodule : tb_top
